//--- rtl/cfg_pkg.sv
package cfg_pkg;

  localparam int NSLOT = 20;
  localparam int NRING = 6;
  localparam int NCHAN = 8;

  localparam logic [3:0] T_PORT = 4'hB;
  localparam logic [3:0] T_PAGE = 4'h8;
  localparam logic [3:0] T_RING = 4'h6;
  localparam logic [3:0] T_EXT  = 4'h7;
  localparam logic [2:0] I_PA   = 3'h6;

  localparam logic [4:0] S_PORT = 5'h00;
  localparam logic [4:0] S_PAGE = 5'h02;
  localparam logic [4:0] S_CMD  = 5'h04;
  localparam logic [4:0] S_RING = 5'h06;
  localparam logic [4:0] S_EXT  = 5'h0C;

  localparam int B_HOST_PAR  = 7;
  localparam int B_PAR_EVEN  = 6;
  localparam int B_REQ_SYNC  = 5;
  localparam int B_LSB_FIRST = 4;
  localparam int B_WIDE      = 2;
  localparam int B_PORT_ON   = 0;
  localparam int B_ENTRY_PAR = 7;
  localparam int B_DATA_PAR  = 6;
  localparam int B_ENTRY_B   = 5;
  localparam int B_DATA_B    = 4;
  localparam int B_LOCAL_PAR = 6;
  localparam int B_LOCAL_B   = 4;

  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] M_PORT    = 8'hF5;
  localparam logic [7:0] M_CMD     = 8'h50;
  localparam logic [7:0] M_ALL     = 8'hFF;
  localparam logic [7:0] M_LOCAL   = 8'h57;
  localparam logic [7:0] LOCAL_OK  = 8'h3F;
  localparam logic [7:0] DEST_OK   = 8'hCF;

  localparam logic [4:0] PAGE_SHIFT [0:8] = '{5'h04, 5'h05, 5'h08, 5'h09, 5'h0A,
                                              5'h0B, 5'h0C, 5'h0D, 5'h0E};
  localparam logic [31:0] ENTRY_BYTES = 32'h0000_0008;
  localparam logic [31:0] STEP32      = 32'h0000_0004;
  localparam logic [31:0] STEP64      = 32'h0000_0008;
  localparam logic [4:0]  LOCAL_SHIFT = 5'h0D;

  typedef struct packed {
    logic       valid;
    logic       rd;
    logic [3:0] typ;
    logic [2:0] idx;
    logic [7:0] wdata;
  } ind_req_t;

  typedef struct packed {
    logic host_par;
    logic par_even;
    logic req_sync;
    logic lsb_first;
    logic wide;
    logic on;
  } port_cfg_t;

  typedef struct packed {
    logic       entry_par;
    logic       data_par;
    logic       entry_b;
    logic       data_b;
    logic [3:0] size;
  } route_t;

  typedef struct packed {
    logic       par;
    logic       port_b;
    logic [4:0] size_log2;
  } local_t;

  typedef struct packed {
    logic par;
    logic port_b;
  } cmd_t;

  typedef enum logic [1:0] {XF_ENTRY, XF_DATA, XF_CMD, XF_LOCAL} xfer_kind_t;

endpackage

//--- rtl/cfg_store.sv
`timescale 1ns/1ns
`default_nettype none
module cfg_store
  import cfg_pkg::*;
(
  input  wire logic                   clk_in,
  input  wire logic                   reset_in,
  input  wire logic                   we_in,
  input  wire logic [4:0]             waddr_in,
  input  wire logic [7:0]             wdata_in,
  input  wire logic                   rd_en_in,
  input  wire logic [4:0]             raddr_in,
  input  wire logic                   rzero_in,
  output logic      [7:0]             rdata_out,
  output logic      [NSLOT-1:0][7:0]  all_out
);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      all_out <= {NSLOT{CFG_RESET}};
    end else if (we_in) begin
      all_out[waddr_in] <= wdata_in;
    end
  end

  // Read data is held between reads so the host may sample it late.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_out <= 8'h00;
    end else if (rd_en_in) begin
      rdata_out <= rzero_in ? 8'h00 : all_out[raddr_in];
    end
  end

endmodule
`default_nettype wire

//--- rtl/parity_check.sv
`timescale 1ns/1ns
`default_nettype none
module parity_check #(
  parameter int NB = 1
) (
  input  wire logic            clk_in,
  input  wire logic            reset_in,
  input  wire logic            valid_in,
  input  wire logic            enable_in,
  input  wire logic            even_in,
  input  wire logic [8*NB-1:0] data_in,
  input  wire logic [NB-1:0]   par_in,
  output logic                 err_out
);

  logic [NB-1:0] bad;

  for (genvar b = 0; b < NB; b++) begin : g_byte
    assign bad[b] = (^{data_in[8*b+:8], par_in[b]}) == even_in;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      err_out <= 1'b0;
    end else begin
      err_out <= valid_in & enable_in & (|bad);
    end
  end

endmodule
`default_nettype wire

//--- rtl/port_and_ring_config_regs.sv
`timescale 1ns/1ns
`default_nettype none
module port_and_ring_config_regs (
  input  wire logic                          clk_in,
  input  wire logic                          reset_in,
  input  wire cfg_pkg::ind_req_t [1:0]       ind_req_in,
  output logic                   [1:0]       ind_done_out,
  output logic                   [1:0]       ind_miss_out,
  output logic                   [7:0]       ind_rdata_out,
  input  wire logic              [7:0]       ext_local_mode_in,
  output cfg_pkg::port_cfg_t     [1:0]       port_cfg_out,
  input  wire logic              [1:0]       cs_n_in,
  input  wire logic              [1:0]       req_pending_in,
  output logic                   [1:0]       req_out,
  input  wire logic              [1:0][31:0] cur_addr_in,
  input  wire logic              [1:0][31:0] next_addr_in,
  output logic                   [1:0]       same_page_out,
  output cfg_pkg::cmd_t          [1:0]       cmd_route_out,
  output cfg_pkg::route_t        [5:0]       ring_route_out,
  output cfg_pkg::route_t        [7:0]       dest_route_out,
  output cfg_pkg::local_t        [7:0]       local_out,
  input  wire logic                          ring_step_valid_in,
  input  wire logic                          ring_step_dest_in,
  input  wire logic              [2:0]       ring_step_sel_in,
  input  wire logic              [31:0]      ring_addr_in,
  output logic                               ring_addr_valid_out,
  output logic                   [31:0]      ring_addr_out,
  input  wire logic              [1:0]       host_wr_valid_in,
  input  wire logic              [1:0][7:0]  host_wr_data_in,
  input  wire logic              [1:0]       host_wr_par_in,
  output logic                   [1:0]       host_par_err_out,
  input  wire logic                          xfer_valid_in,
  input  wire cfg_pkg::xfer_kind_t           xfer_kind_in,
  input  wire logic                          xfer_dest_in,
  input  wire logic              [2:0]       xfer_chan_in,
  input  wire logic              [31:0]      xfer_data_in,
  input  wire logic              [3:0]       xfer_par_in,
  output logic                               xfer_par_err_out
);
  import cfg_pkg::*;

  // Type and index to storage slot; bit 5 flags a mapped register.
  function automatic logic [5:0] decode(input logic [3:0] t, input logic [2:0] i);
    logic hi;
    hi = (i >= I_PA);
    decode = 6'h00;
    case (t)
      T_PORT: if (hi) decode = {1'b1, S_PORT + 5'(i[0])};
      T_PAGE: if (hi) decode = {1'b1, S_PAGE + 5'(i[0])};
      T_RING: decode = hi ? {1'b1, S_CMD + 5'(i[0])} : {1'b1, S_RING + 5'(i)};
      T_EXT:  decode = {1'b1, S_EXT + 5'(i)};
      default: decode = 6'h00;
    endcase
  endfunction

  // Writable bits per slot; everything else stays zero.
  function automatic logic [7:0] wmask(input logic [4:0] s, input logic [7:0] lm);
    if (s < S_PAGE) begin
      wmask = M_PORT;
    end else if (s < S_CMD) begin
      wmask = M_ALL;
    end else if (s < S_RING) begin
      wmask = M_CMD;
    end else if (s < S_EXT) begin
      wmask = M_ALL;
    end else begin
      wmask = lm[3'(s - S_EXT)] ? M_LOCAL : M_ALL;
    end
  endfunction

  function automatic route_t mk_route(input logic [7:0] r, input logic w);
    mk_route = {r[B_ENTRY_PAR], r[B_DATA_PAR], r[B_ENTRY_B] & ~w, r[B_DATA_B] & ~w, r[3:0]};
  endfunction

  function automatic logic [3:0] ones(input logic [7:0] v);
    ones = 4'h0;
    for (int k = 0; k < 8; k++) begin
      ones = ones + 4'(v[k]);
    end
  endfunction

  // Indirect access from either port's access register.
  logic [1:0]            done_q;
  logic [1:0]            done_d;
  logic [1:0]            miss_q;
  logic [1:0]            miss_d;
  logic [NSLOT-1:0][7:0] cfg;
  logic [7:0]            lm_eff;

  wire       take_a = ind_req_in[0].valid & ~done_q[0];
  wire       take_b = ind_req_in[1].valid & ~done_q[1] & ~take_a;
  wire       take   = take_a | take_b;
  ind_req_t  acc;
  assign acc = take_a ? ind_req_in[0] : ind_req_in[1];
  wire [5:0] dec    = decode(acc.typ, acc.idx);
  wire       hit    = dec[5];
  wire [4:0] slot   = dec[4:0];
  wire       do_wr  = take & hit & ~acc.rd;
  wire       do_rd  = take & acc.rd;
  wire [7:0] wval   = acc.wdata & wmask(slot, lm_eff);

  assign lm_eff = ext_local_mode_in & LOCAL_OK;
  assign done_d = {take_b, take_a};
  assign miss_d = {take_b & ~hit, take_a & ~hit};

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      done_q <= 2'h0;
      miss_q <= 2'h0;
    end else begin
      done_q <= done_d;
      miss_q <= miss_d;
    end
  end

  assign ind_done_out = done_q;
  assign ind_miss_out = miss_q;

  cfg_store u_store (
    .clk_in    (clk_in),
    .reset_in  (reset_in),
    .we_in     (do_wr),
    .waddr_in  (slot),
    .wdata_in  (wval),
    .rd_en_in  (do_rd),
    .raddr_in  (slot),
    .rzero_in  (~hit),
    .rdata_out (ind_rdata_out),
    .all_out   (cfg)
  );

  // Port control decode; port B copies port A in 64-bit mode.
  port_cfg_t [1:0] ctl_raw;
  port_cfg_t [1:0] ctl_d;
  port_cfg_t [1:0] ctl_q;

  for (genvar p = 0; p < 2; p++) begin : g_port
    assign ctl_raw[p] = {cfg[S_PORT + p][B_HOST_PAR], cfg[S_PORT][B_PAR_EVEN], cfg[S_PORT + p][B_REQ_SYNC],
                         cfg[S_PORT + p][B_LSB_FIRST], cfg[S_PORT + p][B_WIDE] & (p == 0),
                         cfg[S_PORT + p][B_PORT_ON]};
  end

  wire wide = ctl_raw[0].wide;
  assign ctl_d[0] = ctl_raw[0];
  assign ctl_d[1] = wide ? ctl_raw[0] : ctl_raw[1];

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctl_q <= '0;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  assign port_cfg_out = ctl_q;

  // Request outputs from idle; chip select is a pin and is synchronised first.
  logic [1:0] cs_m_q;
  logic [1:0] cs_s_q;
  logic [1:0] req_q;
  logic [1:0] req_d;

  for (genvar p = 0; p < 2; p++) begin : g_req
    assign req_d[p] = ctl_q[p].on & req_pending_in[p] &
                      (~ctl_q[p].req_sync | ~cs_s_q[p] | req_q[p]);
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cs_m_q <= 2'h3;
      cs_s_q <= 2'h3;
      req_q  <= 2'h0;
    end else begin
      cs_m_q <= cs_n_in;
      cs_s_q <= cs_m_q;
      req_q  <= req_d;
    end
  end

  assign req_out = req_q;

  // Page indication per port.
  logic [1:0] same_d;
  logic [1:0] same_q;

  for (genvar p = 0; p < 2; p++) begin : g_page
    wire [4:0]  sh = PAGE_SHIFT[ones(cfg[S_PAGE + p])];
    wire [31:0] df = cur_addr_in[p] ^ next_addr_in[p];
    assign same_d[p] = (df >> sh) == 32'h0000_0000;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      same_q <= 2'h0;
    end else begin
      same_q <= same_d;
    end
  end

  assign same_page_out = same_q;

  // Command source, ring, destination ring and local memory decode.
  cmd_t   [1:0] cmd_d;
  route_t [5:0] ring_d;
  route_t [7:0] dest_d;
  local_t [7:0] loc_d;

  for (genvar p = 0; p < 2; p++) begin : g_cmd
    assign cmd_d[p] = {cfg[S_CMD + p][B_DATA_PAR], cfg[S_CMD + p][B_DATA_B] & ~wide};
  end

  for (genvar r = 0; r < NRING; r++) begin : g_ring
    assign ring_d[r] = mk_route(cfg[S_RING + r], wide);
  end

  for (genvar c = 0; c < NCHAN; c++) begin : g_ext
    wire [7:0] e = cfg[S_EXT + c];
    wire       l = lm_eff[c];
    assign dest_d[c] = (DEST_OK[c] & ~l) ? mk_route(e, wide) : '0;
    assign loc_d[c]  = l ? {e[B_LOCAL_PAR], e[B_LOCAL_B], LOCAL_SHIFT + 5'(e[2:0])} : '0;
  end

  cmd_t   [1:0] cmd_q;
  route_t [5:0] ring_q;
  route_t [7:0] dest_q;
  local_t [7:0] loc_q;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cmd_q  <= '0;
      ring_q <= '0;
      dest_q <= '0;
      loc_q  <= '0;
    end else begin
      cmd_q  <= cmd_d;
      ring_q <= ring_d;
      dest_q <= dest_d;
      loc_q  <= loc_d;
    end
  end

  assign cmd_route_out  = cmd_q;
  assign ring_route_out = ring_q;
  assign dest_route_out = dest_q;
  assign local_out      = loc_q;

  // Ring address step with wrap inside the size-aligned region.
  // The step follows the fetch width, so 32-bit ports move a half entry.
  wire        rs_ok   = ring_step_dest_in ? DEST_OK[ring_step_sel_in] & ~lm_eff[ring_step_sel_in]
                                          : (ring_step_sel_in < 3'(NRING));
  wire [3:0]  rs_code = ring_step_dest_in ? cfg[S_EXT + 5'(ring_step_sel_in)][3:0]
                                          : cfg[S_RING + 5'(ring_step_sel_in)][3:0];
  wire [31:0] rs_mask = (ENTRY_BYTES << rs_code) - 32'h0000_0001;
  wire [31:0] rs_step = wide ? STEP64 : STEP32;
  wire [31:0] rs_inc  = ring_addr_in + rs_step;
  wire [31:0] rs_next = (ring_addr_in & ~rs_mask) | (rs_inc & rs_mask);

  logic        rav_q;
  logic [31:0] ra_q;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rav_q <= 1'b0;
      ra_q  <= 32'h0000_0000;
    end else begin
      rav_q <= ring_step_valid_in & rs_ok;
      ra_q  <= (ring_step_valid_in & rs_ok) ? rs_next : ra_q;
    end
  end

  assign ring_addr_valid_out = rav_q;
  assign ring_addr_out       = ra_q;

  // Parity checking; polarity for the whole device comes from port A.
  wire even = ctl_q[0].par_even;

  for (genvar p = 0; p < 2; p++) begin : g_hpar
    parity_check #(.NB(1)) u_hpar (
      .clk_in    (clk_in),
      .reset_in  (reset_in),
      .valid_in  (host_wr_valid_in[p]),
      .enable_in (ctl_q[p].host_par),
      .even_in   (even),
      .data_in   (host_wr_data_in[p]),
      .par_in    (host_wr_par_in[p]),
      .err_out   (host_par_err_out[p])
    );
  end

  // Enable is picked by transfer kind; channels past the ring count use the extension register.
  wire   ring_ch = ~xfer_dest_in & (xfer_chan_in < 3'(NRING));
  route_t xr;
  assign xr = ring_ch ? ring_q[xfer_chan_in] : dest_q[xfer_chan_in];
  logic  xen;

  always_comb begin
    case (xfer_kind_in)
      XF_ENTRY: xen = xr.entry_par;
      XF_DATA:  xen = xr.data_par;
      XF_CMD:   xen = cmd_q[xfer_chan_in[0]].par;
      XF_LOCAL: xen = loc_q[xfer_chan_in].par;
      default:  xen = 1'b0;
    endcase
  end

  parity_check #(.NB(4)) u_xpar (
    .clk_in    (clk_in),
    .reset_in  (reset_in),
    .valid_in  (xfer_valid_in),
    .enable_in (xen),
    .even_in   (even),
    .data_in   (xfer_data_in),
    .par_in    (xfer_par_in),
    .err_out   (xfer_par_err_out)
  );

endmodule
`default_nettype wire

//--- testbench/cfg_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module cfg_monitor (
  input wire logic                       clk_in,
  input wire logic                       reset_in,
  input wire cfg_pkg::ind_req_t  [1:0]   ind_req_in,
  input wire logic               [1:0]   ind_done_out,
  input wire logic               [1:0]   ind_miss_out,
  input wire logic               [7:0]   ind_rdata_out,
  input wire cfg_pkg::port_cfg_t [1:0]   port_cfg_out,
  input wire logic               [1:0]   req_pending_in,
  input wire logic               [1:0]   req_out,
  input wire logic                       ring_step_valid_in,
  input wire logic                       ring_step_dest_in,
  input wire logic               [2:0]   ring_step_sel_in,
  input wire logic               [31:0]  ring_addr_in,
  input wire logic                       ring_addr_valid_out,
  input wire logic               [31:0]  ring_addr_out,
  input wire cfg_pkg::route_t    [5:0]   ring_route_out,
  input wire cfg_pkg::local_t    [7:0]   local_out,
  input wire logic               [1:0]   host_wr_valid_in,
  input wire logic               [1:0]   host_par_err_out
);
  import cfg_pkg::*;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  a_miss_with_done: assert property (ind_miss_out[0] |-> ind_done_out[0])
    else $error("Miss pulse without done pulse.");
  a_done_from_req: assert property (ind_done_out[0] |-> $past(ind_req_in[0].valid))
    else $error("Done without a held request.");
  a_done_single: assert property (ind_done_out[0] |=> !ind_done_out[0])
    else $error("Held request taken twice.");
  a_miss_reads_zero: assert property (ind_miss_out[0] && $past(ind_req_in[0].rd) |-> ind_rdata_out == 8'h00)
    else $error("Unmapped read gave nonzero data.");
  a_wide_mirror: assert property (port_cfg_out[0].wide |-> port_cfg_out[1] == port_cfg_out[0])
    else $error("Wide port A does not govern port B.");
  a_off_no_req: assert property ((!port_cfg_out[0].on) [*3] |-> !req_out[0])
    else $error("Request from a disabled port.");
  a_async_req: assert property ((port_cfg_out[0].on && !port_cfg_out[0].req_sync && req_pending_in[0]) [*3]
                                |-> req_out[0])
    else $error("Idle request not asserted.");
  a_ring_step: assert property (ring_step_valid_in |=> ring_addr_valid_out)
    else $error("Ring step not answered.");
  // The stepped address must stay inside the region aligned to the ring's byte length.
  a_ring_wrap: assert property (ring_step_valid_in && !ring_step_dest_in && ring_step_sel_in == 3'h0
    |=> ((ring_addr_out ^ $past(ring_addr_in)) >> ($past(ring_route_out[0].size) + 5'h03)) == 32'h0)
    else $error("Ring address left its region.");
  a_local_size: assert property (local_out[0] != 7'h00 |-> local_out[0].size_log2 inside {[5'h0D:5'h14]})
    else $error("Local space size out of range.");
  a_par_cause: assert property (host_par_err_out[0] |-> $past(host_wr_valid_in[0] && port_cfg_out[0].host_par))
    else $error("Host parity error without checked write.");
  c_read_done: cover property (ind_done_out[0] && $past(ind_req_in[0].rd));
  c_ring_wrap: cover property (ring_addr_valid_out && ring_addr_out == 32'h0000_1BC0);
  c_par_err: cover property (host_par_err_out[0]);
endmodule
`default_nettype wire

//--- testbench/host_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input  wire logic              clk_in,
  input  wire logic              reset_in,
  input  wire logic              go_in,
  input  wire cfg_pkg::ind_req_t cmd_in,
  input  wire logic              done_in,
  output cfg_pkg::ind_req_t      req_out
);
  import cfg_pkg::*;
  // Released fields are scrambled so that a design reading them late sees junk.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      req_out <= '0;
    end else if (done_in) begin
      req_out <= {1'b0, ~req_out[15:0]};
    end else if (go_in) begin
      req_out <= cmd_in;
    end
  end
endmodule
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import cfg_pkg::*;
  logic                clk_in, reset_in, ring_step_valid_in, ring_step_dest_in, ring_addr_valid_out;
  logic                xfer_valid_in, xfer_dest_in, xfer_par_err_out, w, l, ms;
  ind_req_t  [1:0]     ind_req_in, cmd;
  logic      [1:0]     go, ind_done_out, ind_miss_out, cs_n_in, req_pending_in, req_out, same_page_out;
  logic      [1:0]     host_wr_valid_in, host_wr_par_in, host_par_err_out;
  logic      [7:0]     ind_rdata_out, ext_local_mode_in, v, rd_v;
  logic      [1:0][7:0] host_wr_data_in;
  logic      [1:0][31:0] cur_addr_in, next_addr_in;
  port_cfg_t [1:0]     port_cfg_out;
  cmd_t      [1:0]     cmd_route_out;
  route_t    [5:0]     ring_route_out;
  route_t    [7:0]     dest_route_out;
  local_t    [7:0]     local_out;
  logic      [2:0]     ring_step_sel_in, xfer_chan_in;
  logic      [31:0]    ring_addr_in, ring_addr_out, xfer_data_in, base;
  logic      [3:0]     xfer_par_in;
  xfer_kind_t          xfer_kind_in;
  logic      [7:0]     exp_q [20];
  int                  n_mismatch, check_count, seed, r, k, p, s;

  port_and_ring_config_regs u_dut (.*);
  host_model u_host_a (.clk_in(clk_in), .reset_in(reset_in), .go_in(go[0]), .cmd_in(cmd[0]),
                       .done_in(ind_done_out[0]), .req_out(ind_req_in[0]));
  host_model u_host_b (.clk_in(clk_in), .reset_in(reset_in), .go_in(go[1]), .cmd_in(cmd[1]),
                       .done_in(ind_done_out[1]), .req_out(ind_req_in[1]));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic close_out();
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic acc(input int pt, input logic rd, input logic [6:0] a, input logic [7:0] wd, output logic m);
    int n;
    @(negedge clk_in);
    cmd[pt] = {1'b1, rd, a, wd};
    go[pt] = 1'b1;
    @(negedge clk_in);
    go[pt] = 1'b0;
    for (n = 0; n < 20 && ind_done_out[pt] !== 1'b1; n++) @(negedge clk_in);
    if (n == 20) begin
      n_mismatch++;
      close_out();
    end
    rd_v = ind_rdata_out;
    m = ind_miss_out[pt];
  endtask

  function automatic logic [6:0] addr_of(input int i);
    if (i < 6) return {i < 2 ? 4'hB : i < 4 ? 4'h8 : 4'h6, 3'(6 + i % 2)};
    if (i < 12) return {4'h6, 3'(i - 6)};
    return {4'h7, 3'(i - 12)};
  endfunction

  // Reserved positions differ by kind; local-mode extension keeps bits 6, 4 and 2:0 only.
  function automatic logic [7:0] mask_of(input int i);
    if (i < 2) return 8'hF5;
    if (i >= 4 && i < 6) return 8'h50;
    if (i >= 12 && i < 18 && ext_local_mode_in[i - 12]) return 8'h57;
    return 8'hFF;
  endfunction

  initial begin
    n_mismatch = 0;
    check_count = 0;
    seed = 90;
    reset_in = 1'b1;
    {go, cmd, req_pending_in, cur_addr_in, next_addr_in, ring_step_valid_in, ring_step_dest_in} = '0;
    {ring_step_sel_in, ring_addr_in, host_wr_valid_in, host_wr_data_in, host_wr_par_in} = '0;
    {xfer_valid_in, xfer_dest_in, xfer_chan_in, xfer_data_in, xfer_par_in} = '0;
    xfer_kind_in = XF_ENTRY;
    cs_n_in = 2'b11;
    ext_local_mode_in = 8'hC5;
    for (k = 0; k < 20; k++) exp_q[k] = 8'h00;
    repeat (5) @(negedge clk_in);
    reset_in = 1'b0;
    for (r = 0; r < 2; r++) begin
      for (k = 0; k < 20; k++) begin
        acc((k + r) % 2, 1'b1, addr_of(k), 8'h00, ms);
        chk(rd_v, exp_q[k]);
        chk(ms, 1'b0);
        v = $random(seed);
        if (k < 2) v[2] = (k == 0) && r[0];
        acc((k + r + 1) % 2, 1'b0, addr_of(k), v, ms);
        exp_q[k] = v & mask_of(k);
      end
      repeat (3) @(negedge clk_in);
      w = exp_q[0][2];
      for (p = 0; p < 2; p++) begin
        v = exp_q[w ? 0 : p];
        chk(port_cfg_out[p], {v[7], exp_q[0][6], v[5:4], v[2], v[0]});
        chk(cmd_route_out[p], {exp_q[4 + p][6], exp_q[4 + p][4] & ~w});
      end
      for (k = 0; k < 6; k++) begin
        v = exp_q[6 + k];
        chk(ring_route_out[k], {v[7:6], v[5:4] & {2{~w}}, v[3:0]});
      end
      for (k = 0; k < 8; k++) begin
        v = exp_q[12 + k];
        l = k < 6 && ext_local_mode_in[k];
        chk(local_out[k], l ? {v[6], v[4], 5'(13 + v[2:0])} : 7'h00);
        chk(dest_route_out[k], (l || k == 4 || k == 5) ? 8'h00 : {v[7:6], v[5:4] & {2{~w}}, v[3:0]});
      end
    end
    for (k = 0; k < 4; k++) begin
      acc(k / 2, ~k[0], {4'(k * 5), 3'(k)}, 8'hFF, ms);
      chk(ms, 1'b1);
      chk(rd_v, 8'h00);
    end
    acc(0, 1'b0, {4'h6, 3'h6}, 8'h40, ms);
    acc(0, 1'b0, {4'h7, 3'h0}, 8'h40, ms);
    acc(0, 1'b0, {4'h6, 3'h0}, 8'h83, ms);
    acc(1, 1'b0, {4'hB, 3'h7}, 8'h21, ms);
    acc(0, 1'b0, {4'hB, 3'h6}, 8'h81, ms);
    repeat (3) @(negedge clk_in);
    for (k = 0; k < 4; k++) begin
      @(negedge clk_in);
      xfer_kind_in = xfer_kind_t'(k);
      xfer_valid_in = 1'b1;
      @(negedge clk_in);
      xfer_valid_in = 1'b0;
      chk(xfer_par_err_out, k != 1);
    end
    for (k = 0; k < 2; k++) begin
      @(negedge clk_in);
      ring_addr_in = k ? 32'h0000_1BFC : 32'h0000_1BF8;
      ring_step_valid_in = 1'b1;
      @(negedge clk_in);
      ring_step_valid_in = 1'b0;
      chk(ring_addr_valid_out, 1'b1);
      chk(ring_addr_out, k ? 32'h0000_1BC0 : 32'h0000_1BFC);
    end
    for (k = 0; k < 9; k++) begin
      acc(0, 1'b0, {4'h8, 3'h6}, 8'((1 << k) - 1), ms);
      acc(1, 1'b0, {4'h8, 3'h7}, 8'((1 << k) - 1), ms);
      s = k == 0 ? 4 : k == 1 ? 5 : k + 6;
      base = $random(seed) << s;
      repeat (3) @(negedge clk_in);
      cur_addr_in = {2{base}};
      next_addr_in = {2{base + 32'((1 << s) - 1)}};
      @(negedge clk_in);
      chk(same_page_out, 2'b11);
      next_addr_in = {2{base + 32'(1 << s)}};
      @(negedge clk_in);
      chk(same_page_out, 2'b00);
    end
    req_pending_in = 2'b11;
    repeat (6) @(negedge clk_in);
    chk(req_out, 2'b01);
    cs_n_in = 2'b01;
    repeat (6) @(negedge clk_in);
    chk(req_out, 2'b11);
    for (k = 0; k < 4; k++) begin
      acc(0, 1'b0, {4'hB, 3'h6}, {1'b1, k[1], 6'h01}, ms);
      repeat (3) @(negedge clk_in);
      host_wr_data_in = {2{8'hA5}};
      host_wr_par_in = {2{k[0]}};
      host_wr_valid_in = 2'b11;
      @(negedge clk_in);
      host_wr_valid_in = 2'b00;
      chk(host_par_err_out, {1'b0, k[0] == k[1]});
    end
    acc(0, 1'b0, {4'hB, 3'h6}, 8'h80, ms);
    repeat (6) @(negedge clk_in);
    chk(req_out[0], 1'b0);
    close_out();
  end
endmodule
bind port_and_ring_config_regs cfg_monitor u_mon (.*);
`default_nettype wire
